// [seeps_consts.vh]
// seeps_consts.vh: constants for the serial nonvolatile memory slave
// assumes: included by bare name from the design files
`ifndef SEEPS_CONSTS_VH
`define SEEPS_CONSTS_VH
// instruction codes, bit 3 of read and write masked out
`define SEEPS_OP_SET_LATCH   8'h06
`define SEEPS_OP_CLR_LATCH   8'h04
`define SEEPS_OP_READ_STATE  8'h05
`define SEEPS_OP_WRITE_STATE 8'h01
`define SEEPS_OP_READ_MEM    8'h03
`define SEEPS_OP_WRITE_MEM   8'h02
`define SEEPS_OP_MASK        8'hF7
// state byte field positions
`define SEEPS_ST_BUSY_BIT    0
`define SEEPS_ST_LATCH_BIT   1
`define SEEPS_ST_PROT_LO_BIT 2
`define SEEPS_ST_PROT_HI_BIT 3
`define SEEPS_ST_TOP_ONES    4'hF
// reset values
`define SEEPS_RST_PROTECT    2'h0
// programming cycle time in microseconds, and clock rate in kHz
`define SEEPS_PROG_TIME_US   5000
`define SEEPS_CLK_KHZ        10000
`define SEEPS_PROG_CYCLES    ((`SEEPS_PROG_TIME_US * `SEEPS_CLK_KHZ) / 1000)
`endif

// [seeps_mem.v]
// seeps_mem.v: byte array with registered read data
// assumes: single clock, one write port, one read port
`timescale 1ns/1ns
`default_nettype none
module seeps_mem #(
    parameter AW = 9
) (
    // clock
    input  wire          core_clk_i,
    // write port
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [7:0]    wr_data_i,
    // read port
    input  wire [AW-1:0] rd_addr_i,
    output reg  [7:0]    rd_data_o
);
    reg [7:0] mem_ff [0:(1<<AW)-1];

    // write and registered read
    always @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_ff[rd_addr_i];
    end
endmodule
`default_nettype wire

// [seeps_slave.v]
// seeps_slave.v: serial command slave for a small nonvolatile byte memory
// assumes: host link pins are asynchronous and sampled on core_clk_i,
// serial clock well below a quarter of the core clock
`timescale 1ns/1ns
`default_nettype none
`include "seeps_consts.vh"
module seeps_slave #(
    parameter AW         = 9,
    parameter PAGE_BYTES = 32,
    parameter PROG_CYCLES = `SEEPS_PROG_CYCLES
) (
    // clock and reset
    input  wire core_clk_i,
    input  wire nrst_i,
    // serial link pins
    input  wire sck_i,
    input  wire cs_n_i,
    input  wire si_i,
    output reg  so_o,
    output reg  so_oe_o,
    // write guard pin
    input  wire write_guard_n_i
);
    localparam PB = $clog2(PAGE_BYTES);
    // session states
    localparam S_OP   = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_WDAT = 3'd2;
    localparam S_RDAT = 3'd3;
    localparam S_STAT = 3'd4;
    localparam S_SDAT = 3'd5;
    localparam S_IDLE = 3'd6;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    reg [2:0] sck_s_ff;
    reg [2:0] cs_s_ff;
    reg [2:0] si_s_ff;
    reg [2:0] wg_s_ff;
    reg       sck_q_ff;
    reg       cs_q_ff;
    reg       wg_q_ff;

    // three stages, a change counts when stages two and three agree
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_s_ff <= 3'h0;
            cs_s_ff  <= 3'h7;
            si_s_ff  <= 3'h0;
            wg_s_ff  <= 3'h0;
            sck_q_ff <= 1'b0;
            cs_q_ff  <= 1'b1;
            wg_q_ff  <= 1'b0;
        end else begin
            sck_s_ff <= {sck_s_ff[1:0], sck_i};
            cs_s_ff  <= {cs_s_ff[1:0], cs_n_i};
            si_s_ff  <= {si_s_ff[1:0], si_i};
            wg_s_ff  <= {wg_s_ff[1:0], write_guard_n_i};
            if (sck_s_ff[1] == sck_s_ff[2]) sck_q_ff <= sck_s_ff[2];
            if (cs_s_ff[1] == cs_s_ff[2])   cs_q_ff  <= cs_s_ff[2];
            if (wg_s_ff[1] == wg_s_ff[2])   wg_q_ff  <= wg_s_ff[2];
        end
    end

    wire stable_sck = (sck_s_ff[1] == sck_s_ff[2]);
    wire stable_cs  = (cs_s_ff[1] == cs_s_ff[2]);
    // rising edge samples, either idle level
    wire sck_rise   = stable_sck && sck_s_ff[2] && !sck_q_ff && !cs_q_ff;
    wire sck_fall   = stable_sck && !sck_s_ff[2] && sck_q_ff && !cs_q_ff;
    wire cs_fall    = stable_cs && !cs_s_ff[2] && cs_q_ff;
    wire cs_rise    = stable_cs && cs_s_ff[2] && !cs_q_ff;

    // ************************************************************
    // session state and storage
    // ************************************************************
    reg [2:0]    state_ff;
    reg [2:0]    bit_cnt_ff;
    reg [7:0]    shin_ff;
    reg [7:0]    shout_ff;
    reg          is_write_ff;
    reg [AW-1:0] addr_ff;
    reg          latch_ff;
    reg [1:0]    protect_ff;
    reg          busy_ff;
    reg [31:0]   prog_cnt_ff;
    reg          cmd_ok_ff;
    reg [1:0]    cmd_kind_ff;
    reg [7:0]    page_buf_ff [0:PAGE_BYTES-1];
    reg [PB-1:0] ld_cnt_ff;
    reg [PB:0]   nbytes_ff;
    reg [7:0]    new_state_ff;
    reg          guard_lost_ff;
    reg [PB:0]   prog_idx_ff;
    reg [AW-1:0] prog_base_ff;
    reg [PB:0]   prog_len_ff;
    reg          mem_busy_ff;
    reg          load_next_ff;
    reg          fetch_ff;

    // commit kinds at select rise
    localparam K_NONE  = 2'd0;
    localparam K_LATCH = 2'd1;
    localparam K_STATE = 2'd2;
    localparam K_MEM   = 2'd3;

    wire [7:0] next_byte = {shin_ff[6:0], si_s_ff[2]};
    wire       byte_done = sck_rise && (bit_cnt_ff == 3'd7);
    wire [7:0] state_byte = {`SEEPS_ST_TOP_ONES, protect_ff, latch_ff, busy_ff};

    // protected region lower bound per code
    function prot_hit;
        input [AW-1:0] a;
        input [1:0]    code;
        begin
            case (code)
                2'd1:    prot_hit = (a[AW-1:AW-2] == 2'b11);
                2'd2:    prot_hit = a[AW-1];
                2'd3:    prot_hit = 1'b1;
                default: prot_hit = 1'b0;
            endcase
        end
    endfunction

    // memory instance, read address is the session pointer
    wire [7:0]    mem_rd;
    wire [AW-1:0] prog_addr = {prog_base_ff[AW-1:PB],
                               prog_base_ff[PB-1:0] + prog_idx_ff[PB-1:0]};
    seeps_mem #(.AW(AW)) u_mem (
        .core_clk_i (core_clk_i),
        .wr_en_i    (mem_busy_ff),
        .wr_addr_i  (prog_addr),
        .wr_data_i  (page_buf_ff[prog_idx_ff[PB-1:0]]),
        .rd_addr_i  (addr_ff),
        .rd_data_o  (mem_rd)
    );

    // ************************************************************
    // serial protocol engine
    // ************************************************************
    integer i;
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_ff      <= S_IDLE;
            bit_cnt_ff    <= 3'd0;
            shin_ff       <= 8'h00;
            shout_ff      <= 8'h00;
            is_write_ff   <= 1'b0;
            addr_ff       <= {AW{1'b0}};
            latch_ff      <= 1'b0; // writes disabled
            protect_ff    <= `SEEPS_RST_PROTECT;
            busy_ff       <= 1'b0;
            prog_cnt_ff   <= 32'd0;
            cmd_ok_ff     <= 1'b0;
            cmd_kind_ff   <= K_NONE;
            ld_cnt_ff     <= {PB{1'b0}};
            nbytes_ff     <= {(PB+1){1'b0}};
            new_state_ff  <= 8'h00;
            guard_lost_ff <= 1'b0;
            prog_idx_ff   <= {(PB+1){1'b0}};
            prog_base_ff  <= {AW{1'b0}};
            prog_len_ff   <= {(PB+1){1'b0}};
            mem_busy_ff   <= 1'b0;
            load_next_ff  <= 1'b0;
            fetch_ff      <= 1'b0;
            so_o          <= 1'b0;
            so_oe_o       <= 1'b0;
            for (i = 0; i < PAGE_BYTES; i = i + 1) page_buf_ff[i] <= 8'h00;
        end else begin
            load_next_ff <= 1'b0;
            // busy for the interval, then clears
            if (busy_ff) begin
                if (mem_busy_ff) begin
                    if (prog_idx_ff + 1'b1 >= prog_len_ff) mem_busy_ff <= 1'b0;
                    prog_idx_ff <= prog_idx_ff + 1'b1;
                end
                if (prog_cnt_ff >= PROG_CYCLES - 1) begin
                    busy_ff  <= 1'b0;
                    latch_ff <= 1'b0; // back to write disable after cycle
                end
                prog_cnt_ff <= prog_cnt_ff + 32'd1;
            end
            // guard low during session aborts the write
            if (!cs_q_ff && !wg_q_ff) guard_lost_ff <= 1'b1;
            if (cs_fall) begin
                state_ff      <= S_OP;
                bit_cnt_ff    <= 3'd0;
                cmd_kind_ff   <= K_NONE;
                nbytes_ff     <= {(PB+1){1'b0}};
                guard_lost_ff <= !wg_q_ff;
            end else if (cs_rise) begin
                state_ff <= S_IDLE;
                so_oe_o  <= 1'b0;
                if (cmd_kind_ff == K_LATCH && !busy_ff) latch_ff <= 1'b1;
                // protect bits, bits 2 and 3 only
                if (cmd_kind_ff == K_STATE && latch_ff && !guard_lost_ff && wg_q_ff && !busy_ff
                        && bit_cnt_ff == 3'd0 && nbytes_ff != 0) begin
                    protect_ff  <= new_state_ff[`SEEPS_ST_PROT_HI_BIT:`SEEPS_ST_PROT_LO_BIT];
                    busy_ff     <= 1'b1;
                    prog_cnt_ff <= 32'd0;
                end
                // program only after data, latch, unprotected
                if (cmd_kind_ff == K_MEM && latch_ff && !guard_lost_ff && wg_q_ff && !busy_ff
                        && bit_cnt_ff == 3'd0 && nbytes_ff != 0
                        && !prot_hit(prog_base_ff, protect_ff)) begin
                    busy_ff     <= 1'b1;
                    prog_cnt_ff <= 32'd0;
                    mem_busy_ff <= 1'b1;
                    prog_idx_ff <= {(PB+1){1'b0}};
                    prog_len_ff <= nbytes_ff;
                end
            end else if (sck_rise) begin
                shin_ff    <= next_byte;
                bit_cnt_ff <= bit_cnt_ff + 3'd1;
                if (byte_done) begin
                    case (state_ff)
                        S_OP: begin
                            // decode, only state read when busy
                            state_ff <= S_IDLE;
                            if (next_byte == `SEEPS_OP_READ_STATE) begin
                                state_ff <= S_STAT;
                                shout_ff <= state_byte;
                            end else if (busy_ff) begin
                                state_ff <= S_IDLE;
                            end else if (next_byte == `SEEPS_OP_SET_LATCH) begin
                                cmd_kind_ff <= K_LATCH;
                            end else if (next_byte == `SEEPS_OP_CLR_LATCH) begin
                                latch_ff <= 1'b0;
                            end else if (next_byte == `SEEPS_OP_WRITE_STATE) begin
                                state_ff    <= S_SDAT;
                                cmd_kind_ff <= K_STATE;
                            end else if ((next_byte & `SEEPS_OP_MASK) == `SEEPS_OP_READ_MEM
                                    || (next_byte & `SEEPS_OP_MASK) == `SEEPS_OP_WRITE_MEM) begin
                                // bit 3 is address bit eight
                                state_ff    <= S_ADDR;
                                is_write_ff <= !next_byte[0];
                                addr_ff     <= {AW{1'b0}};
                                if (AW > 8) addr_ff[AW-1] <= next_byte[3];
                            end
                        end
                        S_ADDR: begin
                            addr_ff[7:0] <= next_byte;
                            if (is_write_ff) begin
                                state_ff     <= S_WDAT;
                                cmd_kind_ff  <= K_MEM;
                                prog_base_ff <= addr_ff;
                                prog_base_ff[7:0] <= next_byte;
                                ld_cnt_ff    <= {PB{1'b0}};
                            end else begin
                                state_ff     <= S_RDAT;
                                load_next_ff <= 1'b1;
                            end
                        end
                        S_WDAT: begin
                            // page load wraps within the page
                            page_buf_ff[ld_cnt_ff] <= next_byte;
                            ld_cnt_ff <= ld_cnt_ff + 1'b1;
                            if (nbytes_ff != PAGE_BYTES) nbytes_ff <= nbytes_ff + 1'b1;
                        end
                        S_SDAT: begin
                            new_state_ff <= next_byte;
                            nbytes_ff    <= {{PB{1'b0}}, 1'b1};
                            state_ff     <= S_IDLE;
                        end
                        S_RDAT: begin
                            load_next_ff <= 1'b1;
                        end
                        S_STAT: begin
                            shout_ff <= state_byte; // repeat state byte
                        end
                        default: state_ff <= S_IDLE;
                    endcase
                end
            end else if (sck_fall) begin
                // drive only while sending on falling edge
                if (state_ff == S_RDAT || state_ff == S_STAT) begin
                    so_oe_o  <= 1'b1;
                    so_o     <= shout_ff[7];
                    shout_ff <= {shout_ff[6:0], 1'b0};
                end else begin
                    so_oe_o <= 1'b0;
                end
            end
            // registered array byte lands two cycles after pointer set
            fetch_ff <= load_next_ff;
            if (load_next_ff) begin
                addr_ff <= addr_ff + 1'b1;
            end
            if (fetch_ff && state_ff == S_RDAT) begin
                shout_ff <= mem_rd;
            end
        end
    end
endmodule
`default_nettype wire

// [seeps_slave_sva.sv]
// seeps_slave_sva.sv: port checks for the serial memory slave
// assumes: bound to seeps_slave, link pins move on core clock edges
`timescale 1ns/1ns
`default_nettype none
module seeps_slave_sva (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // link pins
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic write_guard_n_i
);
    logic       sck_ff;
    logic [4:0] bits_ff;
    logic [3:0] since_ff;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // rises per session, cycles since last serial clock fall
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_ff   <= 1'b0;
            bits_ff  <= 5'h00;
            since_ff <= 4'hF;
        end else begin
            sck_ff   <= sck_i;
            bits_ff  <= cs_n_i ? 5'h00 : bits_ff + {4'h0, sck_i && !sck_ff && bits_ff != 5'h1F};
            since_ff <= (sck_ff && !sck_i) ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
        end
    end
    property p_idle_off;
        cs_n_i [*6] |-> !so_oe_o;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("output on while idle");
    property p_drop;
        $rose(cs_n_i) |-> ##[1:6] !so_oe_o;
    endproperty
    a_drop: assert property (p_drop) else $error("output kept after select");
    property p_opcode_quiet;
        !cs_n_i && bits_ff < 5'h08 |-> !so_oe_o;
    endproperty
    a_opcode_quiet: assert property (p_opcode_quiet) else $error("output during opcode");
    property p_rise_slot;
        $rose(so_oe_o) |-> bits_ff inside {5'h08, 5'h09, 5'h10, 5'h11};
    endproperty
    a_rise_slot: assert property (p_rise_slot) else $error("output starts off boundary");
    property p_sel_held;
        $rose(so_oe_o) |-> !$past(cs_n_i, 6);
    endproperty
    a_sel_held: assert property (p_sel_held) else $error("output without select");
    property p_shift_fall;
        so_oe_o && $changed(so_o) |-> since_ff inside {[1:5]};
    endproperty
    a_shift_fall: assert property (p_shift_fall) else $error("data not shifted on fall");
    property p_reset_quiet;
        $rose(nrst_i) |-> !so_oe_o && !so_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output on after reset");
    property p_sel_fall_quiet;
        $fell(cs_n_i) |-> !so_oe_o [*8];
    endproperty
    a_sel_fall_quiet: assert property (p_sel_fall_quiet) else $error("output at session start");
endmodule
bind seeps_slave seeps_slave_sva i_sva (
    .core_clk_i      (core_clk_i),
    .nrst_i          (nrst_i),
    .sck_i           (sck_i),
    .cs_n_i          (cs_n_i),
    .si_i            (si_i),
    .so_o            (so_o),
    .so_oe_o         (so_oe_o),
    .write_guard_n_i (write_guard_n_i)
);
`default_nettype wire

// [seeps_host.sv]
// seeps_host.sv: host master model for the serial link
// assumes: one core clock, bit period of eight core cycles
`timescale 1ns/1ns
`default_nettype none
module seeps_host (
    // clock
    input  wire logic core_clk_i,
    // link pins
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    logic idle_hi; // serial clock rest level
    initial begin
        sck_o   = 1'b0;
        cs_n_o  = 1'b1;
        si_o    = 1'b0;
        idle_hi = 1'b0;
    end
    task automatic sel(input logic hi);
        idle_hi = hi;
        sck_o  <= hi;
        repeat (8) @(posedge core_clk_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_o <= 1'b0;
            si_o  <= tx[i];
            repeat (4) @(posedge core_clk_i);
            sck_o <= 1'b1;
            repeat (3) @(posedge core_clk_i);
            rx[i] = so_oe_i ? so_i : ~so_i;
            @(posedge core_clk_i);
        end
    endtask
    task automatic desel();
        sck_o  <= idle_hi;
        repeat (4) @(posedge core_clk_i);
        cs_n_o <= 1'b1;
        si_o   <= ~si_o;
        repeat (8) @(posedge core_clk_i);
    endtask
endmodule
`default_nettype wire

// [seeps_slave_bench.sv]
// seeps_slave_bench.sv: self-checking bench for the serial memory slave
// assumes: host model and bound checker compiled before
`timescale 1ns/1ns
`default_nettype none
module seeps_slave_bench;
    localparam int PROG = 600;
    logic       core_clk_i;
    logic       nrst_i;
    logic       write_guard_n_i;
    wire        sck, cs_n, si, so, so_oe;
    int         miscompares;
    int         n_tests;
    logic [7:0] rx;
    logic [1:0] pc;
    logic [8:0] sa [6] = '{9'h1A5, 9'h1A6, 9'h1FF, 9'h000, 9'h180, 9'h100};
    logic [7:0] sd [6] = '{8'h3C, 8'h5D, 8'hA1, 8'hB2, 8'h11, 8'h22};
    logic [8:0] pa [3] = '{9'h180, 9'h100, 9'h000};
    logic [8:0] fa [3] = '{9'h17F, 9'h0FF, 9'h1FF};
    logic [7:0] fd [3] = '{8'h41, 8'h42, 8'hA1};
    logic [7:0] kd [3] = '{8'h11, 8'h22, 8'hB2};
    seeps_slave #(.PROG_CYCLES(PROG)) i_dut (
        .core_clk_i      (core_clk_i),
        .nrst_i          (nrst_i),
        .sck_i           (sck),
        .cs_n_i          (cs_n),
        .si_i            (si),
        .so_o            (so),
        .so_oe_o         (so_oe),
        .write_guard_n_i (write_guard_n_i)
    );
    seeps_host i_host (
        .core_clk_i (core_clk_i),
        .sck_o      (sck),
        .cs_n_o     (cs_n),
        .si_o       (si),
        .so_i       (so),
        .so_oe_i    (so_oe)
    );
    always #50 core_clk_i = ~core_clk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op1(input logic [7:0] op);
        i_host.sel(1'b0);
        i_host.xb(op, rx);
        i_host.desel();
    endtask
    task automatic read_state_byte_cmd(input logic [7:0] exp);
        i_host.sel(1'b1);
        i_host.xb(8'h05, rx);
        i_host.xb(8'h00, rx);
        i_host.desel();
        chk(rx, exp);
    endtask
    // memory write, state byte read right after unless st is zero
    task automatic wmem(input logic [8:0] a, input logic [7:0] d, input logic [7:0] st, input logic en);
        if (en) op1(8'h06); // latch set in earlier session
        i_host.sel(1'b0);
        i_host.xb({4'h0, a[8], 3'b010}, rx);
        i_host.xb(a[7:0], rx);
        i_host.xb(d, rx);
        i_host.desel();
        if (st != 8'h00) read_state_byte_cmd(st);
    endtask
    task automatic settle();
        repeat (PROG + 20) @(posedge core_clk_i);
    endtask
    task automatic wst(input logic [7:0] d);
        i_host.sel(1'b0);
        i_host.xb(8'h01, rx);
        i_host.xb(d, rx);
        i_host.desel();
        settle();
    endtask
    task automatic rd(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1, input logic hi);
        i_host.sel(hi);
        i_host.xb({4'h0, a[8], 3'b011}, rx);
        i_host.xb(a[7:0], rx);
        i_host.xb(8'h00, rx);
        chk(rx, e0);
        i_host.xb(8'h00, rx);
        chk(rx, e1);
        i_host.desel();
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge core_clk_i);
        miscompares++;
        stop_test();
    end
    initial begin
        core_clk_i      = 1'b0;
        nrst_i          = 1'b0;
        write_guard_n_i = 1'b1;
        miscompares     = 0;
        n_tests         = 0;
        repeat (16) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        read_state_byte_cmd(8'hF0); // writes off
        op1(8'h0E);
        op1(8'h86);
        read_state_byte_cmd(8'hF0); // unlisted codes ignored
        op1(8'h06);
        read_state_byte_cmd(8'hF2); // latch set
        op1(8'h04);
        read_state_byte_cmd(8'hF0); // latch cleared
        wmem(9'h1A5, 8'h3C, 8'hF3, 1'b1); // busy shown
        op1(8'h04);
        read_state_byte_cmd(8'hF3); // clear ignored while busy
        settle();
        read_state_byte_cmd(8'hF0); // busy and latch drop
        for (int i = 1; i < 6; i++) begin
            wmem(sa[i], sd[i], 8'hF3, 1'b1); // seed bytes
            settle();
        end
        rd(9'h1A5, 8'h3C, 8'h5D, 1'b0); // stream read
        wmem(9'h1A5, 8'hC3, 8'hF0, 1'b0); // no latch
        settle();
        write_guard_n_i <= 1'b0;
        wmem(9'h1A5, 8'hC3, 8'h00, 1'b1);
        write_guard_n_i <= 1'b1;
        settle();
        rd(9'h1A5, 8'h3C, 8'h5D, 1'b1); // guard blocks write
        for (int c = 0; c < 3; c++) begin
            pc = 2'(c + 1);
            op1(8'h06);
            wst({4'h0, pc, 2'h3});
            read_state_byte_cmd({4'hF, pc, 2'h0}); // code kept
            wmem(pa[c], 8'hEE, {4'hF, pc, 2'h2}, 1'b1); // refused
            if (c < 2) wmem(fa[c], fd[c], {4'hF, pc, 2'h3}, 1'b1);
            settle();
            rd(fa[c], fd[c], kd[c], 1'b1); // edges and wrap
        end
        op1(8'h04);
        wst(8'h00);
        read_state_byte_cmd(8'hFC); // state write needs latch
        stop_test();
    end
endmodule
`default_nettype wire
